// ### hw/cst_map.svh
// Register offsets, field encodings, reset values and timing counts
`ifndef CST_MAP_SVH
`define CST_MAP_SVH
`define CST_CTRL_OFS      8'h00
`define CST_AGGSEL_OFS    8'h04
`define CST_TRIBSEL_OFS   8'h08
`define CST_CODES_OFS     8'h0c
`define CST_STATUS_OFS    8'h10
`define CST_LIVE_OFS      8'h14
`define CST_EVENT_OFS     8'h18
`define CST_CODE_NULL     4'h0
`define CST_SEL_ZERO      2'h0
`define CST_SEL_ONE       2'h1
`define CST_SEL_CARRY     2'h2
`define CST_SEL_ADPCM     2'h3
`define CST_AGGSEL_RST    8'h44
`define CST_TRIBSEL_RST   8'h44
`define CST_LIVE_WIN      8'd32
`define CST_SEV_NONE      2'h0
`define CST_SEV_MINOR     2'h1
`define CST_SEV_MAJOR     2'h2
`define CST_SEV_CRIT      2'h3
`endif

// ### hw/cst_pkg.sv
// Types shared by the signalling termination block
package cst_pkg;
  typedef struct packed {
    logic [3:0] abcd;
    logic       valid;
  } cst_sig_t;
  typedef struct packed {
    logic       adminLock;
    logic       emMode;
    logic       protoNull;
    logic [1:0] submode;
  } cst_ctrl_t;
endpackage

// ### hw/cst_signalling_termination.sv
// Channel-associated signalling termination with AHB-Lite registers
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cst_map.svh"
module cst_signalling_termination
  import cst_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hsel,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire cst_sig_t    tribIn,
  input  wire cst_sig_t    aggIn,
  input  wire logic        sigCondErr,
  input  wire logic        aisDetect,
  input  wire logic        equipDisabled,
  output cst_sig_t         aggOut,
  output cst_sig_t         tribOut,
  output logic [1:0]       alarmSeverity,
  output logic             operEnabled,
  output logic             commsAlarmEvt,
  output logic             stateChangeEvt
);
  // ------------------------------------------------------------------
  // Input synchronisers for asynchronous status levels
  // ------------------------------------------------------------------
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_r <= 3'h0;
      syncB_r <= 3'h0;
    end else begin
      syncA_r <= {equipDisabled, aisDetect, sigCondErr};
      syncB_r <= syncA_r;
    end
  end
  wire logic adminLock;
  // Locked: condition errors and AIS are not detected; equipment fault still is
  wire logic condErr  = syncB_r[0] & ~adminLock;
  wire logic aisSeen  = syncB_r[1] & ~adminLock;
  wire logic eqDis    = syncB_r[2];
  wire logic faultNow = condErr | aisSeen;

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  cst_ctrl_t  ctrl_r;
  logic [7:0] aggSel_r;
  logic [7:0] tribSel_r;
  logic [15:0] codes_r;
  logic [1:0] evtSticky_r;
  assign adminLock = ctrl_r.adminLock;
  wire logic [3:0] aggFault   = codes_r[3:0];
  wire logic [3:0] aggSusp    = codes_r[7:4];
  wire logic [3:0] tribFault  = codes_r[11:8];
  wire logic [3:0] tribSusp   = codes_r[15:12];
  wire logic       protoNull  = ctrl_r.protoNull;

  // ------------------------------------------------------------------
  // AHB-Lite slave: address phase capture, zero wait state
  // ------------------------------------------------------------------
  logic       wrPend_r;
  logic       rdPend_r;
  logic [7:0] addr_r;
  wire logic  phaseOk = hsel & hready & htrans[1];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      addr_r   <= 8'h00;
    end else begin
      wrPend_r <= phaseOk & hwrite;
      rdPend_r <= phaseOk & ~hwrite;
      addr_r   <= haddr[7:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  wire logic wrCtrl  = wrPend_r & (addr_r == `CST_CTRL_OFS);
  wire logic wrAgg   = wrPend_r & (addr_r == `CST_AGGSEL_OFS);
  wire logic wrTrib  = wrPend_r & (addr_r == `CST_TRIBSEL_OFS);
  wire logic wrCodes = wrPend_r & (addr_r == `CST_CODES_OFS);
  wire logic wrEvt   = wrPend_r & (addr_r == `CST_EVENT_OFS);

  // Fault code 0 is null; 1..F legal
  wire logic [3:0] wAggFault = hwdata[3:0];
  // Bits b,d have no ADPCM option; keep old value
  wire logic [7:0] aggSelW = {
    (hwdata[7:6] == `CST_SEL_ADPCM) ? aggSel_r[7:6] : hwdata[7:6],
    hwdata[5:4],
    (hwdata[3:2] == `CST_SEL_ADPCM) ? aggSel_r[3:2] : hwdata[3:2],
    hwdata[1:0]};
  // Tributary channels: three settings each
  wire logic [7:0] tribSelW = {
    (hwdata[7:6] == `CST_SEL_ADPCM) ? tribSel_r[7:6] : hwdata[7:6],
    (hwdata[5:4] == `CST_SEL_ADPCM) ? tribSel_r[5:4] : hwdata[5:4],
    (hwdata[3:2] == `CST_SEL_ADPCM) ? tribSel_r[3:2] : hwdata[3:2],
    (hwdata[1:0] == `CST_SEL_ADPCM) ? tribSel_r[1:0] : hwdata[1:0]};

  // Register writes; lock bit touches no operational state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r    <= '{adminLock: 1'b0, emMode: 1'b0, protoNull: 1'b1,
                     submode: 2'h0};
      aggSel_r  <= `CST_AGGSEL_RST;
      tribSel_r <= `CST_TRIBSEL_RST;
      codes_r   <= 16'h0000;
    end else begin
      if (wrCtrl) begin
        ctrl_r.adminLock <= hwdata[0];
        ctrl_r.emMode    <= hwdata[1];
        ctrl_r.protoNull <= hwdata[2];
        // Null protocol forces null submode
        ctrl_r.submode   <= hwdata[2] ? 2'h0 : hwdata[5:4];
      end else if (protoNull) begin
        ctrl_r.submode   <= 2'h0;
      end
      if (wrAgg) aggSel_r <= aggSelW;
      if (wrTrib) tribSel_r <= tribSelW;
      if (wrCodes) codes_r <= {hwdata[15:4], wAggFault};
    end
  end

  // ------------------------------------------------------------------
  // Aggregate direction: suspend/fault, then per-bit forcing
  // ------------------------------------------------------------------
  wire logic useSuspAgg  = adminLock & protoNull;
  wire logic useFaultAgg = ~adminLock & faultNow &
                           (aggFault != `CST_CODE_NULL);
  wire logic [3:0] aggBase = useSuspAgg ? aggSusp :
                             useFaultAgg ? aggFault : tribIn.abcd;
  logic [3:0] aggForced;
  logic [3:0] adpcmBits;
  // ADPCM mode: invert a/c so idle all-zero code stays rare
  assign adpcmBits = ~aggBase;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_aggbit
      wire logic [1:0] s = aggSel_r[2*gi+1:2*gi];
      // Force applied after substitution
      assign aggForced[3-gi] =
        (s == `CST_SEL_ZERO) ? 1'b0 :
        (s == `CST_SEL_ONE)  ? 1'b1 :
        (s == `CST_SEL_CARRY) ? aggBase[3-gi] :
        adpcmBits[3-gi];
    end
  endgenerate
  // Null protocol carries bits untouched unless locked/faulted
  wire logic [3:0] aggPre = (protoNull & ~useSuspAgg & ~useFaultAgg) ?
                            aggBase : aggForced;
  // All-zero code would upset multiframe alignment
  wire logic [3:0] aggFinal = (aggPre == 4'h0) ? 4'h1 : aggPre;

  // ------------------------------------------------------------------
  // Tributary direction: suspend/fault, then E&M channel forcing
  // ------------------------------------------------------------------
  wire logic useSuspTrib  = adminLock & protoNull;
  wire logic useFaultTrib = ~adminLock & faultNow & protoNull;
  wire logic [3:0] tribBase = useSuspTrib ? tribSusp :
                              useFaultTrib ? tribFault : aggIn.abcd;
  logic [3:0] tribForced;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_tribch
      wire logic [1:0] s = tribSel_r[2*gi+1:2*gi];
      assign tribForced[3-gi] =
        (s == `CST_SEL_ZERO) ? 1'b0 :
        (s == `CST_SEL_ONE)  ? 1'b1 : tribBase[3-gi];
    end
  endgenerate
  wire logic [3:0] tribFinal = ctrl_r.emMode ? tribForced : tribBase;

  // One update per multiframe strobe (valid)
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aggOut  <= '{abcd: 4'hd, valid: 1'b0};
      tribOut <= '{abcd: 4'hd, valid: 1'b0};
    end else begin
      aggOut.valid  <= tribIn.valid;
      tribOut.valid <= aggIn.valid;
      if (tribIn.valid) aggOut.abcd <= aggFinal;
      if (aggIn.valid) tribOut.abcd <= tribFinal;
    end
  end

  // ------------------------------------------------------------------
  // Live bit states: per bit on/off/toggling over a window
  // ------------------------------------------------------------------
  logic [7:0]  winCnt_r;
  logic [7:0]  chg_r;
  logic [15:0] live_r;
  logic [15:0] liveNxt;
  wire logic   winEnd = (winCnt_r == `CST_LIVE_WIN - 8'd1);
  wire logic [7:0] bitsNow = {aggOut.abcd, aggIn.abcd};
  logic [7:0] bitsLast_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      winCnt_r   <= 8'h00;
      chg_r      <= 8'h00;
      bitsLast_r <= 8'h00;
      live_r     <= 16'h0000;
    end else begin
      bitsLast_r <= bitsNow;
      winCnt_r   <= winEnd ? 8'h00 : winCnt_r + 8'd1;
      chg_r      <= winEnd ? 8'h00 : chg_r | (bitsNow ^ bitsLast_r);
      if (winEnd) live_r <= liveNxt;
    end
  end
  // Code per bit: 00 off, 01 on, 10 toggling
  generate
    for (gi = 0; gi < 8; gi++) begin : g_live
      wire logic tog = chg_r[gi] | (bitsNow[gi] ^ bitsLast_r[gi]);
      assign liveNxt[2*gi+1:2*gi] = tog ? 2'h2 : {1'b0, bitsNow[gi]};
    end
  endgenerate

  // ------------------------------------------------------------------
  // Operational state, alarm severity and events
  // ------------------------------------------------------------------
  // Lock freezes the error seen by the state, so that locking
  // alone never flips the reported state
  logic       errHeld_r;
  wire logic  operErr = adminLock ? errHeld_r : syncB_r[0];
  wire logic  operNxt = ~(operErr | eqDis);
  logic       operLast_r;
  logic       errLast_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      operLast_r     <= 1'b1;
      errLast_r      <= 1'b0;
      errHeld_r      <= 1'b0;
      operEnabled    <= 1'b1;
      alarmSeverity  <= `CST_SEV_NONE;
      commsAlarmEvt  <= 1'b0;
      stateChangeEvt <= 1'b0;
      evtSticky_r    <= 2'h0;
    end else begin
      operLast_r     <= operNxt;
      errLast_r      <= condErr;
      errHeld_r      <= operErr;
      operEnabled    <= operNxt;
      // Worst active alarm wins
      alarmSeverity  <= eqDis ? `CST_SEV_CRIT :
                        condErr ? `CST_SEV_MAJOR :
                        aisSeen ? `CST_SEV_MINOR : `CST_SEV_NONE;
      commsAlarmEvt  <= condErr & ~errLast_r;
      stateChangeEvt <= operNxt ^ operLast_r;
      // Sticky copies; a new event beats a write-one clear
      evtSticky_r    <= (evtSticky_r & ~({2{wrEvt}} & hwdata[1:0])) |
                        {operNxt ^ operLast_r, condErr & ~errLast_r};
    end
  end

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  wire logic [31:0] rdMux =
    (addr_r == `CST_CTRL_OFS)    ? {26'h0, ctrl_r.submode, 1'b0,
                                    ctrl_r.protoNull, ctrl_r.emMode,
                                    ctrl_r.adminLock} :
    (addr_r == `CST_AGGSEL_OFS)  ? {24'h0, aggSel_r} :
    (addr_r == `CST_TRIBSEL_OFS) ? {24'h0, tribSel_r} :
    (addr_r == `CST_CODES_OFS)   ? {16'h0, codes_r} :
    (addr_r == `CST_STATUS_OFS)  ? {24'h0, aggOut.abcd, alarmSeverity,
                                    faultNow, operEnabled} :
    (addr_r == `CST_LIVE_OFS)    ? {16'h0, live_r} :
    (addr_r == `CST_EVENT_OFS)   ? {30'h0, evtSticky_r} : 32'h0;
  assign hrdata = rdPend_r ? rdMux : 32'h0;
endmodule

// ### verif/cst_sigterm_asserts.sv
// Port-level checks of the signalling termination
`timescale 1ns/1ps
module cst_sigterm_asserts
  import cst_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire cst_sig_t   tribIn,
  input wire cst_sig_t   aggIn,
  input wire logic       sigCondErr,
  input wire logic       equipDisabled,
  input wire cst_sig_t   aggOut,
  input wire cst_sig_t   tribOut,
  input wire logic [1:0] alarmSeverity,
  input wire logic       operEnabled,
  input wire logic       commsAlarmEvt,
  input wire logic       stateChangeEvt
);
  // Single domain, reset aborts every check
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Equipment fault held past the synchroniser
  sequence s_equip_held;
    equipDisabled [*4];
  endsequence
  // Slot timing, zero guard, alarms and state
  a_agg_slot_lag: assert property (tribIn.valid |=> aggOut.valid)
    else $error("aggregate slot not answered");
  a_agg_code_holds: assert property (!tribIn.valid |=>
    !aggOut.valid && $stable(aggOut.abcd)) else $error("code moved");
  a_trib_slot_lag: assert property (aggIn.valid |=> tribOut.valid)
    else $error("tributary slot not answered");
  a_no_zero_code: assert property (aggOut.valid |-> |aggOut.abcd)
    else $error("aggregate code zero");
  a_alarm_event: assert property ($rose(sigCondErr) |-> ##[1:5]
    commsAlarmEvt) else $error("alarm event missing");
  a_event_single: assert property (commsAlarmEvt |=> !commsAlarmEvt)
    else $error("alarm event too long");
  a_oper_drop: assert property ($rose(equipDisabled) |-> ##[1:5]
    !operEnabled) else $error("still enabled");
  a_state_event: assert property ($changed(operEnabled) |-> ##[0:1]
    stateChangeEvt) else $error("state event missing");
  a_sev_critical: assert property (s_equip_held |=>
    alarmSeverity == 2'h3) else $error("severity not critical");
endmodule
bind cst_signalling_termination cst_sigterm_asserts i_chk (
  .clk(clk), .rst_b(rst_b), .tribIn(tribIn), .aggIn(aggIn),
  .sigCondErr(sigCondErr), .equipDisabled(equipDisabled),
  .aggOut(aggOut), .tribOut(tribOut), .alarmSeverity(alarmSeverity),
  .operEnabled(operEnabled), .commsAlarmEvt(commsAlarmEvt),
  .stateChangeEvt(stateChangeEvt));

// ### verif/cst_far_end.sv
// Far-end model: tributary and aggregate signalling sources
`timescale 1ns/1ps
module cst_far_end
  import cst_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       sendReq,
  input  wire logic [3:0] tribCode,
  input  wire logic [3:0] aggCode,
  output cst_sig_t        tribIn,
  output cst_sig_t        aggIn
);
  // One slot per request; code lines churn between slots
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tribIn <= '0;
      aggIn  <= '0;
    end else begin
      tribIn.valid <= sendReq;
      aggIn.valid  <= sendReq;
      tribIn.abcd  <= sendReq ? tribCode : ~tribIn.abcd;
      aggIn.abcd   <= sendReq ? aggCode : ~aggIn.abcd;
    end
  end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the signalling termination block
`timescale 1ns/1ps
`include "cst_map.svh"
module testbench import cst_pkg::*; ;
  logic        clk = 1'b0, rst_b = 1'b0, hwrite = 1'b0, sendReq = 1'b0;
  logic        sigCondErr = 1'b0, aisDetect = 1'b0, equipDisabled = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [3:0]  tribCode = '0, aggCode = '0;
  logic [1:0]  htrans = '0, alarmSeverity;
  logic        hreadyout, hresp, operEnabled, commsAlarmEvt, stateChangeEvt;
  cst_sig_t    tribIn, aggIn, aggOut, tribOut;
  int          errors = 0, samples_checked = 0, cycles = 0;
  // Design and far-end sources
  cst_signalling_termination i_dut (
    .clk(clk), .rst_b(rst_b), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(1'b1),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tribIn(tribIn), .aggIn(aggIn),
    .sigCondErr(sigCondErr), .aisDetect(aisDetect),
    .equipDisabled(equipDisabled), .aggOut(aggOut), .tribOut(tribOut),
    .alarmSeverity(alarmSeverity), .operEnabled(operEnabled),
    .commsAlarmEvt(commsAlarmEvt), .stateChangeEvt(stateChangeEvt));
  cst_far_end i_far (.clk(clk), .rst_b(rst_b), .sendReq(sendReq),
    .tribCode(tribCode), .aggCode(aggCode), .tribIn(tribIn), .aggIn(aggIn));
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Single AHB-Lite word transfer; a read compares against d
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    if (!wr) chk(hrdata, d);
    chk(32'(hresp), 32'h0);
  endtask
  // One slot each way, both outputs compared
  task automatic link(input logic [3:0] tc, ac, ea, et);
    tribCode <= tc;
    aggCode <= ac;
    sendReq <= 1'b1;
    @(posedge clk);
    sendReq <= 1'b0;
    do @(posedge clk); while (aggOut.valid !== 1'b1);
    chk({28'h0, aggOut.abcd}, {28'h0, ea});
    chk({28'h0, tribOut.abcd}, {28'h0, et});
  endtask
  task automatic t_regs();
    bus(1'b0, `CST_CTRL_OFS, 32'h4);
    bus(1'b0, `CST_AGGSEL_OFS, 32'h44);
    bus(1'b0, `CST_TRIBSEL_OFS, 32'h44);
    bus(1'b0, 8'h1c, 32'h0);
    bus(1'b1, `CST_CTRL_OFS, 32'h34);
    bus(1'b0, `CST_CTRL_OFS, 32'h4);
    link(4'h5, 4'h9, 4'h5, 4'h9);
    link(4'h0, 4'h0, 4'h1, 4'h0);
    // Two full windows: aggregate out steady, far end churning
    repeat (70) @(posedge clk);
    bus(1'b0, `CST_LIVE_OFS, 32'h1aa);
  endtask
  task automatic t_select();
    bus(1'b1, `CST_CTRL_OFS, 32'h2);
    bus(1'b1, `CST_AGGSEL_OFS, 32'h93);
    bus(1'b1, `CST_TRIBSEL_OFS, 32'ha1);
    link(4'h9, 4'h3, 4'h3, 4'hb);
    link(4'h6, 4'hc, 4'ha, 4'h8);
  endtask
  task automatic t_fault();
    bus(1'b1, `CST_CTRL_OFS, 32'h4);
    bus(1'b1, `CST_AGGSEL_OFS, 32'ha9);
    bus(1'b1, `CST_CODES_OFS, 32'hca36);
    aisDetect <= 1'b1;
    repeat (5) @(posedge clk);
    chk(32'(alarmSeverity), 32'h1);
    link(4'h9, 4'h5, 4'he, 4'ha);
    sigCondErr <= 1'b1;
    repeat (5) @(posedge clk);
    chk(32'(alarmSeverity), 32'h2);
    chk(32'(operEnabled), 32'h0);
    bus(1'b0, `CST_EVENT_OFS, 32'h3);
    bus(1'b1, `CST_EVENT_OFS, 32'h3);
    bus(1'b0, `CST_EVENT_OFS, 32'h0);
    bus(1'b1, `CST_CODES_OFS, 32'hca30);
    link(4'h9, 4'h5, 4'h9, 4'ha);
    bus(1'b1, `CST_CTRL_OFS, 32'h5);
    link(4'h9, 4'h5, 4'hb, 4'hc);
    chk(32'(operEnabled), 32'h0);
    chk(32'(alarmSeverity), 32'h0);
    bus(1'b1, `CST_CTRL_OFS, 32'h4);
    sigCondErr <= 1'b0;
    aisDetect <= 1'b0;
    equipDisabled <= 1'b1;
    repeat (5) @(posedge clk);
    chk(32'(alarmSeverity), 32'h3);
    bus(1'b1, `CST_CTRL_OFS, 32'h5);
    repeat (5) @(posedge clk);
    chk(32'(operEnabled), 32'h0);
    equipDisabled <= 1'b0;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_select();
    t_fault();
    end_sim();
  end
endmodule
